// ---- rtl/ebpo_pkg.sv ----
package ebpo_pkg;

  localparam int DUTY_W = 10;
  localparam int DB_W = 7;

  // Output configuration encodings.
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;

  // Field positions.
  localparam int DIR_BIT = 1;
  localparam int FULL_BIT = 0;
  localparam int POL_AC_BIT = 1;
  localparam int POL_BD_BIT = 0;

  // Reset values.
  localparam logic [DUTY_W-1:0] DUTY_RST = 10'h000;
  localparam logic [DB_W-1:0] DB_CNT_RST = 7'h00;
  localparam logic [1:0] CFG_RST = 2'h0;

endpackage

// ---- rtl/ebpo_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module ebpo_top (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control fields.
  input wire logic pwm_enable,
  input wire logic [7:0] duty_upper_byte,
  input wire logic [1:0] duty_low_bits,
  input wire logic [1:0] output_config_select,
  input wire logic [ebpo_pkg::DB_W-1:0] deadband_count,
  input wire logic [1:0] output_polarity_select,
  input wire logic [7:0] period_compare_register,
  // Period timer.
  input wire logic [7:0] period_timer,
  input wire logic [1:0] timer_fine,
  input wire logic timer_tick,
  input wire logic cycle_tick,
  // Outputs.
  output logic bridge_out_a,
  output logic bridge_out_b,
  output logic bridge_out_c,
  output logic bridge_out_d,
  output logic [ebpo_pkg::DUTY_W-1:0] duty_shadow_register,
  output logic [1:0] active_config
);

  logic pwm_raw;
  logic early_sw;
  logic db_on [2];
  logic [ebpo_pkg::DB_W-1:0] db_cnt [2];
  logic [3:0] next_act;

  wire [ebpo_pkg::DUTY_W-1:0] next_duty = {duty_upper_byte, duty_low_bits};
  wire period_match = (period_timer == period_compare_register);
  wire boundary = timer_tick & period_match;
  wire duty_hit = (duty_shadow_register == {period_timer, timer_fine});
  wire duty_zero = (next_duty == ebpo_pkg::DUTY_RST);
  wire full_new = output_config_select[ebpo_pkg::FULL_BIT];
  wire full_cur = active_config[ebpo_pkg::FULL_BIT];
  wire dir_new = output_config_select[ebpo_pkg::DIR_BIT];
  wire dir_change = full_cur & full_new &
    (dir_new != active_config[ebpo_pkg::DIR_BIT]);
  wire pol_ac = output_polarity_select[ebpo_pkg::POL_AC_BIT];
  wire pol_bd = output_polarity_select[ebpo_pkg::POL_BD_BIT];
  wire load_now = boundary | ~pwm_enable;
  wire db_src [2];
  assign db_src[0] = pwm_raw;
  assign db_src[1] = ~pwm_raw;

  // Shadow duty and configuration load at the period boundary, and every cycle while PWM is disabled.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      duty_shadow_register <= ebpo_pkg::DUTY_RST;
      active_config <= ebpo_pkg::CFG_RST;
    end else if (load_now) begin
      duty_shadow_register <= next_duty;
      active_config <= output_config_select;
    end
  end

  // Raw waveform: set at boundary unless zero, cleared on duty match.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pwm_raw <= 1'b0;
    end else if (!pwm_enable) begin
      pwm_raw <= 1'b0;
    end else if (boundary) begin
      pwm_raw <= ~duty_zero;
    end else if (duty_hit) begin
      pwm_raw <= 1'b0;
    end
  end

  // Early swap window before the boundary on a direction change.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      early_sw <= 1'b0;
    end else if (boundary || !pwm_enable) begin
      early_sw <= 1'b0;
    end else if (period_match && dir_change) begin
      early_sw <= 1'b1;
    end
  end

  // Dead-band delay for each half-bridge phase.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_db
      always_ff @(posedge core_clk) begin
        if (sys_rst || !db_src[gi]) begin
          db_cnt[gi] <= ebpo_pkg::DB_CNT_RST;
          db_on[gi] <= 1'b0;
        end else if (!db_on[gi]) begin
          if (db_cnt[gi] >= deadband_count) begin
            db_on[gi] <= 1'b1;
          end else if (cycle_tick) begin
            db_cnt[gi] <= db_cnt[gi] + 7'h01;
          end
        end
      end
    end
  endgenerate

  // Active levels of outputs in order d, c, b, a.
  always_comb begin
    next_act = 4'h0;
    if (pwm_enable) begin
      if (early_sw) begin
        next_act = dir_new ? 4'h4 : 4'h1;
      end else begin
        case (active_config)
          ebpo_pkg::CFG_SINGLE: next_act = {3'h0, pwm_raw};
          ebpo_pkg::CFG_HALF: next_act = {2'h0, db_on[1], db_on[0]};
          ebpo_pkg::CFG_FWD: next_act = {pwm_raw, 3'h1};
          ebpo_pkg::CFG_REV: next_act = {2'h1, pwm_raw, 1'b0};
          default: next_act = 4'h0;
        endcase
      end
    end
  end

  // Polarity applied per pair, outputs registered.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      bridge_out_a <= 1'b0;
      bridge_out_b <= 1'b0;
      bridge_out_c <= 1'b0;
      bridge_out_d <= 1'b0;
    end else begin
      bridge_out_a <= next_act[0] ^ pol_ac;
      bridge_out_b <= next_act[1] ^ pol_bd;
      bridge_out_c <= next_act[2] ^ pol_ac;
      bridge_out_d <= next_act[3] ^ pol_bd;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_fwd_steady;
    pwm_enable && active_config == ebpo_pkg::CFG_FWD && !early_sw;
  endsequence

  sequence s_rev_steady;
    pwm_enable && active_config == ebpo_pkg::CFG_REV && !early_sw;
  endsequence

  chk_shadow_hold: assert property (
    pwm_enable && !boundary |=> $stable(duty_shadow_register))
    else $error("Shadow duty changed outside period boundary.");

  chk_shadow_load: assert property (
    pwm_enable && boundary |=> duty_shadow_register == $past(next_duty))
    else $error("Shadow duty not loaded at period boundary.");

  chk_period_set: assert property (
    pwm_enable && boundary |=> pwm_raw == !$past(duty_zero))
    else $error("Waveform not set correctly at period start.");

  chk_duty_clear: assert property (
    pwm_enable && duty_hit && !boundary |=> !pwm_raw)
    else $error("Waveform not cleared on duty match.");

  chk_config_hold: assert property (
    pwm_enable && !boundary |=> $stable(active_config))
    else $error("Configuration changed mid period.");

  chk_fwd_outputs: assert property (
    s_fwd_steady |=> bridge_out_a == !$past(pol_ac) &&
      bridge_out_b == $past(pol_bd) && bridge_out_c == $past(pol_ac) &&
      bridge_out_d == ($past(pwm_raw) ^ $past(pol_bd)))
    else $error("Forward full-bridge outputs wrong.");

  chk_rev_outputs: assert property (
    s_rev_steady |=> bridge_out_c == !$past(pol_ac) &&
      bridge_out_a == $past(pol_ac) && bridge_out_d == $past(pol_bd) &&
      bridge_out_b == ($past(pwm_raw) ^ $past(pol_bd)))
    else $error("Reverse full-bridge outputs wrong.");

  chk_early_start: assert property (
    pwm_enable && period_match && dir_change && !boundary |=> early_sw)
    else $error("Early direction swap not started.");

  chk_early_quiet: assert property (
    pwm_enable && early_sw |=> bridge_out_b == $past(pol_bd) &&
      bridge_out_d == $past(pol_bd))
    else $error("Modulated output active during swap window.");

  chk_dead_wait: assert property (
    $rose(db_on[0]) |-> $past(db_cnt[0]) >= $past(deadband_count))
    else $error("Dead-band delay cut short.");

  sequence s_single_steady;
    pwm_enable && active_config == ebpo_pkg::CFG_SINGLE && !early_sw;
  endsequence

  sequence s_half_steady;
    pwm_enable && active_config == ebpo_pkg::CFG_HALF && !early_sw;
  endsequence

  chk_dead_wait_b: assert property (
    $rose(db_on[1]) |-> $past(db_cnt[1]) >= $past(deadband_count))
    else $error("Dead-band delay on second phase cut short.");

  chk_dead_src_a: assert property (
    $rose(db_on[0]) |-> $past(pwm_raw))
    else $error("First phase turned on without its source.");

  chk_dead_src_b: assert property (
    $rose(db_on[1]) |-> !$past(pwm_raw))
    else $error("Second phase turned on without its source.");

  chk_dead_drop_a: assert property (
    !pwm_raw |=> !db_on[0])
    else $error("First phase stayed on after its source fell.");

  chk_dead_drop_b: assert property (
    pwm_raw |=> !db_on[1])
    else $error("Second phase stayed on after its source fell.");

  chk_single_outputs: assert property (
    s_single_steady |=> bridge_out_a == ($past(pwm_raw) ^ $past(pol_ac)) &&
      bridge_out_b == $past(pol_bd) && bridge_out_c == $past(pol_ac) &&
      bridge_out_d == $past(pol_bd))
    else $error("Single output mode outputs wrong.");

  chk_half_outputs: assert property (
    s_half_steady |=> bridge_out_a == ($past(db_on[0]) ^ $past(pol_ac)) &&
      bridge_out_b == ($past(db_on[1]) ^ $past(pol_bd)) &&
      bridge_out_c == $past(pol_ac) && bridge_out_d == $past(pol_bd))
    else $error("Half-bridge outputs wrong.");

  chk_raw_hold: assert property (
    pwm_enable && !boundary && !duty_hit |=> $stable(pwm_raw))
    else $error("Waveform changed without boundary or duty match.");

  chk_zero_duty: assert property (
    pwm_enable && boundary && duty_zero |=> !pwm_raw)
    else $error("Waveform set for zero duty.");

  chk_disabled_raw: assert property (
    !pwm_enable |=> !pwm_raw)
    else $error("Waveform active outside PWM mode.");

  chk_disabled_idle: assert property (
    !pwm_enable |=> bridge_out_a == $past(pol_ac) &&
      bridge_out_b == $past(pol_bd) && bridge_out_c == $past(pol_ac) &&
      bridge_out_d == $past(pol_bd))
    else $error("Outputs not inactive outside PWM mode.");

  chk_disabled_follow: assert property (
    !pwm_enable |=> duty_shadow_register == $past(next_duty) &&
      active_config == $past(output_config_select))
    else $error("Shadow or configuration not following outside PWM mode.");

  chk_dir_apply: assert property (
    pwm_enable && boundary |=>
      active_config == $past(output_config_select))
    else $error("Configuration not taken at period boundary.");

  chk_early_end: assert property (
    boundary |=> !early_sw)
    else $error("Swap window outlived the period boundary.");

  chk_early_needs: assert property (
    $rose(early_sw) |-> $past(period_match) && $past(dir_change))
    else $error("Swap window opened without a direction change.");

  chk_early_dir: assert property (
    pwm_enable && early_sw |=>
      bridge_out_a == (!$past(dir_new) ^ $past(pol_ac)) &&
      bridge_out_c == ($past(dir_new) ^ $past(pol_ac)))
    else $error("Unmodulated outputs not swapped in swap window.");

  chk_reset_outputs: assert property (
    disable iff (1'b0) sys_rst |=> !bridge_out_a && !bridge_out_b &&
      !bridge_out_c && !bridge_out_d)
    else $error("Outputs not cleared by reset.");

  chk_reset_state: assert property (
    disable iff (1'b0) sys_rst |=>
      active_config == ebpo_pkg::CFG_RST &&
      duty_shadow_register == ebpo_pkg::DUTY_RST && !pwm_raw)
    else $error("Internal state not cleared by reset.");

endmodule

`default_nettype wire

// ---- sim/ebpo_switch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ebpo_switch_model (
  // Gate drives and their polarity.
  input wire logic gate_a,
  input wire logic gate_b,
  input wire logic gate_c,
  input wire logic gate_d,
  input wire logic [1:0] pol,
  // Leg fault flag.
  output logic shoot_through
);
  wire a_on = gate_a ^ pol[1];
  wire b_on = gate_b ^ pol[0];
  wire c_on = gate_c ^ pol[1];
  wire d_on = gate_d ^ pol[0];
  // Flags a leg whose upper and lower switch are both on.
  assign shoot_through = (a_on & b_on) | (c_on & d_on);
endmodule
`default_nettype wire

// ---- sim/test_ebpo_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_ebpo_top;
  logic core_clk = 0, sys_rst = 1, en = 0;
  logic [7:0] dub = 0, pr = 8'h07;
  logic [1:0] dlb = 0, sel = 0, pol = 0, acfg;
  logic [6:0] db = 0;
  logic [9:0] cnt = 0, sh;
  logic a, b, c, d, st;
  int error_cnt = 0, num_checks = 0, seed = 86, cyc = 0;
  int m_sh = 0, m_cfg = 0, m_r = 0, m_o = 0, ok = 0;
  int m_dc[2], m_do[2], m_h;
  wire [7:0] pt = cnt[9:2];
  wire [1:0] fine = cnt[1:0];
  wire tick = (fine == 2'h3);
  wire bnd = tick && (pt == pr);
  always #50 core_clk = ~core_clk;
  ebpo_top dut (.core_clk(core_clk), .sys_rst(sys_rst), .pwm_enable(en),
    .duty_upper_byte(dub), .duty_low_bits(dlb), .output_config_select(sel),
    .deadband_count(db), .output_polarity_select(pol),
    .period_compare_register(pr), .period_timer(pt), .timer_fine(fine),
    .timer_tick(tick), .cycle_tick(tick), .bridge_out_a(a),
    .bridge_out_b(b), .bridge_out_c(c), .bridge_out_d(d),
    .duty_shadow_register(sh), .active_config(acfg));
  ebpo_switch_model drv (.gate_a(a), .gate_b(b), .gate_c(c), .gate_d(d),
    .pol(pol), .shoot_through(st));
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [9:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [3:0] exp_out(int m, int r, int h, logic [1:0] p);
    logic [3:0] v;
    case (m)
      0: v = {r[0], 3'h0};
      1: v = {3'h4, r[0]};
      2: v = {h[0], h[1], 2'h0};
      default: v = {1'b0, r[0], 2'h2};
    endcase
    return v ^ {p, p};
  endfunction
  // Dead-band reference: each phase counts instruction ticks while high.
  always @(posedge core_clk) begin
    for (int k = 0; k < 2; k++) begin
      if (sys_rst || ((m_r != 0) == (k == 1))) begin
        m_dc[k] <= 0;
        m_do[k] <= 0;
      end else if (m_do[k] == 0) begin
        if (m_dc[k] >= db) m_do[k] <= 1;
        else if (tick) m_dc[k] <= m_dc[k] + 1;
      end
    end
    m_h <= 2 * m_do[1] + m_do[0];
  end
  // Timer stand-in: ten-bit count wrapping at the period boundary.
  always @(posedge core_clk) begin
    #1 cnt = bnd ? 10'h000 : cnt + 10'h001;
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // Reference model of shadow, configuration and modulated level.
  always @(posedge core_clk) begin
    if (sys_rst || !en) begin
      m_sh <= {dub, dlb};
      m_cfg <= sel;
      m_r <= 0;
      m_o <= 0;
      ok <= 0;
    end else begin
      if (bnd) begin
        m_sh <= {dub, dlb};
        m_cfg <= sel;
        m_r <= ({dub, dlb} != 10'h000);
        ok <= (sel == m_cfg);
      end else if (cnt == m_sh) m_r <= 0;
      if (sel != m_cfg) ok <= 0;
      m_o <= m_r;
    end
  end
  always @(negedge core_clk) if (ok) begin
    check("outputs", 10'({a, b, c, d}), 10'(exp_out(m_cfg, m_o, m_h, pol)));
    check("shadow", sh, m_sh[9:0]);
    check("config", 10'(acfg), 10'(m_cfg[1:0]));
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 0;
    for (int i = 0; i < 16; i++) begin
      @(posedge core_clk) #1 en = 0;
      @(posedge core_clk) #1 sel = 2'(i);
      pol = 2'(i >> 2);
      db = 7'($unsigned($random(seed)) % 12);
      @(posedge core_clk) #1 en = 1;
      repeat (96) begin
        @(posedge core_clk) #1;
        if ($random(seed) % 8 == 0) {dub, dlb} = 10'($unsigned($random(seed)) % 40);
      end
    end
    @(posedge core_clk) #1 en = 0;
    @(posedge core_clk) #1 sel = ebpo_pkg::CFG_FWD;
    pol = 2'h0;
    {dub, dlb} = 10'h004;
    @(posedge core_clk) #1 en = 1;
    repeat (45) @(posedge core_clk);
    #1 sel = ebpo_pkg::CFG_REV;
    repeat (64) begin
      @(negedge core_clk);
      check("shoot", 10'(st), 10'h000);
    end
    check("config", 10'(acfg), 10'(ebpo_pkg::CFG_REV));
    print_verdict();
  end
endmodule
`default_nettype wire
